// ---- otde_regs.svh ----
// Purpose: named offsets, fields, reset values and timing for the descriptor engine
// Assumes: 32-bit word registers, byte addresses
// Notes: included by both ends, the retry counter, the checker and the testbench
`ifndef OTDE_REGS_SVH
`define OTDE_REGS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OTDE_OFS_CONTROL 8'h00
`define OTDE_OFS_IRQ_STATUS 8'h04
`define OTDE_OFS_IRQ_SET 8'h08
`define OTDE_OFS_IRQ_CLEAR 8'h0c
`define OTDE_OFS_EHCI_STATUS 8'h10
`define OTDE_OFS_RETRY_LIMIT 8'h14
`define OTDE_OFS_TD_CMD 8'h18
`define OTDE_OFS_TD_INFO 8'h1c
`define OTDE_OFS_TD_BUF 8'h20
`define OTDE_OFS_TD_END 8'h24
`define OTDE_OFS_TD_LINK 8'h28
`define OTDE_OFS_HOST_STAT 8'h2c
// ****************************************
// field positions
// ****************************************
`define OTDE_CTL_PLE_BIT 2
`define OTDE_CTL_IE_BIT 3
`define OTDE_CTL_MIE_BIT 31
`define OTDE_IRQ_UE_BIT 4
`define OTDE_IRQ_WDH_BIT 1
`define OTDE_EHCI_HSE_BIT 4
`define OTDE_INFO_CC_LSB 28
`define OTDE_INFO_EC_LSB 26
`define OTDE_INFO_T_LSB 24
`define OTDE_CMD_GO_BIT 0
`define OTDE_CMD_PERIODIC_BIT 1
`define OTDE_CMD_CARRY_BIT 2
`define OTDE_HST_BUSY_BIT 0
`define OTDE_HST_DONE_BIT 1
`define OTDE_HST_WAITED_BIT 2
`define OTDE_HST_NORESP_BIT 3
// ****************************************
// reset values, codes and timing
// ****************************************
`define OTDE_RETRY_LIMIT_RST 8'h80
`define OTDE_RETRY_OFF 8'h00
`define OTDE_EC_MAX 2'h2
`define OTDE_CC_NOERR 4'h0
`define OTDE_CC_NORESP 4'h5
`define OTDE_CC_PIDFAIL 4'h6
`define OTDE_WR_GAP_NS 84
`define OTDE_CLK_NS 20
`define OTDE_WR_GAP_CYC ((`OTDE_WR_GAP_NS + `OTDE_CLK_NS - 1) / `OTDE_CLK_NS)
`define OTDE_RESUBMIT_MAX 3'h5
`endif

// ---- otde_pkg.sv ----
// Purpose: shared types of the descriptor engine
// Assumes: nothing beyond the register header
// Notes: holds types only
package otde_pkg;
  typedef enum logic [1:0] {OTDE_USB_ACK, OTDE_USB_PIDFAIL, OTDE_USB_NORESP} otde_usb_res_t;
  typedef enum logic [1:0] {OTDE_BUS_OK, OTDE_BUS_RETRY} otde_bus_res_t;
endpackage

// ---- otde_if.sv ----
// Purpose: register port of the descriptor engine between host side and device
// Assumes: single clock, device answers every request with ack
// Notes: one modport per party
`timescale 1ns/100ps
interface otde_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic ack;
  logic irq;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output ack,
    output irq);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input ack,
    input irq);
endinterface

// ---- otde_retry_cnt.sv ----
// Purpose: counts consecutive bus-master retries against the limit
// Assumes: one result per bus-master attempt
// Notes: limit of zero disables the error
`timescale 1ns/100ps
`include "otde_regs.svh"
module otde_retry_cnt
  import otde_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic res_vld,
  input wire logic res_retry,
  input wire logic [W-1:0] limit,
  output logic expired
);
  logic [W:0] cnt_r;
  wire logic [W:0] cnt_nxt = res_retry ? cnt_r + 1'b1 : '0;
  wire logic over = (cnt_nxt > {1'b0, limit}) && (limit != `OTDE_RETRY_OFF);
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (res_vld && !expired)
      cnt_r <= cnt_nxt;
  end
  // saturates via expired so the counter cannot wrap back below the limit
  assign expired = res_vld && over;
endmodule

// ---- otde_dev.sv ----
// Purpose: device end: registers, descriptor engine, retry time-out
// Assumes: usb and bus-master outcomes arrive as one-cycle result strobes
// Notes: one descriptor per go command, packets until it retires or, if periodic, until the list enables drop; packet size given by usb_len
`timescale 1ns/100ps
`include "otde_regs.svh"
module otde_dev
  import otde_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  otde_if.dev bus,
  input wire logic usb_vld,
  input wire otde_usb_res_t usb_res,
  input wire logic [10:0] usb_len,
  input wire logic bm_vld,
  input wire otde_bus_res_t bm_res,
  output logic usb_req_r,
  output logic usb_pid_r,
  output logic [31:0] usb_addr_r,
  output logic carry_out_r
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctl_r;
  logic [31:0] ist_r;
  logic [31:0] ien_r;
  logic [31:0] est_r;
  logic [7:0] lim_r;
  logic [31:0] info_r;
  logic [31:0] cbp_r;
  logic [31:0] be_r;
  logic [31:0] link_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic irq_r;
  logic periodic_r;
  logic carry_r;
  wire logic expired;
  wire logic wr_ctl = bus.wr && bus.addr == `OTDE_OFS_CONTROL;
  wire logic wr_ist = bus.wr && bus.addr == `OTDE_OFS_IRQ_STATUS;
  wire logic wr_ien = bus.wr && bus.addr == `OTDE_OFS_IRQ_SET;
  wire logic wr_idis = bus.wr && bus.addr == `OTDE_OFS_IRQ_CLEAR;
  wire logic wr_est = bus.wr && bus.addr == `OTDE_OFS_EHCI_STATUS;
  wire logic wr_lim = bus.wr && bus.addr == `OTDE_OFS_RETRY_LIMIT;
  wire logic wr_cmd = bus.wr && bus.addr == `OTDE_OFS_TD_CMD;
  wire logic wr_info = bus.wr && bus.addr == `OTDE_OFS_TD_INFO;
  wire logic wr_cbp = bus.wr && bus.addr == `OTDE_OFS_TD_BUF;
  wire logic wr_be = bus.wr && bus.addr == `OTDE_OFS_TD_END;
  wire logic wr_link = bus.wr && bus.addr == `OTDE_OFS_TD_LINK;
  // ****************************************
  // descriptor engine
  // ****************************************
  wire logic [1:0] tog_f = info_r[`OTDE_INFO_T_LSB +: 2];
  wire logic [1:0] ec_f = info_r[`OTDE_INFO_EC_LSB +: 2];
  wire logic tog_cur = tog_f[1] ? tog_f[0] : carry_r;
  wire logic list_ok = ctl_r[`OTDE_CTL_PLE_BIT] && ctl_r[`OTDE_CTL_IE_BIT];
  wire logic go = wr_cmd && bus.wdata[`OTDE_CMD_GO_BIT] && !usb_req_r &&
    (!bus.wdata[`OTDE_CMD_PERIODIC_BIT] || list_ok);
  wire logic good = usb_vld && usb_req_r && usb_res == OTDE_USB_ACK;
  wire logic bad = usb_vld && usb_req_r && usb_res != OTDE_USB_ACK;
  wire logic [3:0] cc_bad = usb_res == OTDE_USB_PIDFAIL ? `OTDE_CC_PIDFAIL : `OTDE_CC_NORESP;
  wire logic retire_bad = bad && ec_f == `OTDE_EC_MAX;
  wire logic [31:0] rem = be_r - cbp_r + 32'h1;
  wire logic last_pkt = {21'h0, usb_len} >= rem;
  wire logic [31:0] cbp_adv = last_pkt ? 32'h0 : cbp_r + {21'h0, usb_len};
  wire logic [31:0] info_good = {`OTDE_CC_NOERR, 2'h0, 1'b1, ~tog_cur, info_r[23:0]};
  // the code always reports the last attempt; the tally stops at its limit on retire
  wire logic [31:0] info_bad = {cc_bad,
    retire_bad ? ec_f : ec_f + 2'h1, info_r[25:0]};
  wire logic retire = retire_bad || (good && last_pkt);
  wire logic [31:0] ist_set = {27'h0, expired, 2'h0, retire, 1'b0};
  wire logic [31:0] est_set = {27'h0, expired, 4'h0};
  wire logic [31:0] rd_mux =
    bus.addr == `OTDE_OFS_CONTROL ? ctl_r :
    bus.addr == `OTDE_OFS_IRQ_STATUS ? ist_r :
    bus.addr == `OTDE_OFS_IRQ_SET ? ien_r :
    bus.addr == `OTDE_OFS_IRQ_CLEAR ? ien_r :
    bus.addr == `OTDE_OFS_EHCI_STATUS ? est_r :
    bus.addr == `OTDE_OFS_RETRY_LIMIT ? {24'h0, lim_r} :
    bus.addr == `OTDE_OFS_TD_CMD ? {29'h0, carry_r, periodic_r, usb_req_r} :
    bus.addr == `OTDE_OFS_TD_INFO ? info_r :
    bus.addr == `OTDE_OFS_TD_BUF ? cbp_r :
    bus.addr == `OTDE_OFS_TD_END ? be_r :
    bus.addr == `OTDE_OFS_TD_LINK ? link_r : 32'h0;
  wire logic irq_nxt = ctl_r[`OTDE_CTL_MIE_BIT] && |(ist_r & ien_r);
  otde_retry_cnt #(.W(8)) u_retry (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .res_vld(bm_vld),
    .res_retry(bm_res == OTDE_BUS_RETRY),
    .limit(lim_r),
    .expired(expired)
  );
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ctl_r <= 32'h0;
      ist_r <= 32'h0;
      ien_r <= 32'h0;
      est_r <= 32'h0;
      lim_r <= `OTDE_RETRY_LIMIT_RST;
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      ack_r <= (bus.wr || bus.rd) && !ack_r;
      rdata_r <= rd_mux;
      irq_r <= irq_nxt;
      if (wr_ctl && !ack_r)
        ctl_r <= bus.wdata;
      // set wins over write-one-to-clear
      ist_r <= (ist_r & ~(wr_ist && !ack_r ? bus.wdata : 32'h0)) | ist_set;
      est_r <= (est_r & ~(wr_est && !ack_r ? bus.wdata : 32'h0)) | est_set;
      if (wr_ien && !ack_r)
        ien_r <= ien_r | bus.wdata;
      else if (wr_idis && !ack_r)
        ien_r <= ien_r & ~bus.wdata;
      if (wr_lim && !ack_r)
        lim_r <= bus.wdata[7:0];
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      info_r <= 32'h0;
      cbp_r <= 32'h0;
      be_r <= 32'h0;
      link_r <= 32'h0;
      usb_req_r <= 1'b0;
      periodic_r <= 1'b0;
      carry_r <= 1'b0;
    end
    else if (usb_req_r)
    begin
      if (good)
      begin
        info_r <= info_good;
        cbp_r <= cbp_adv;
        carry_r <= ~tog_cur;
      end
      else if (bad)
        info_r <= info_bad;
      if (retire)
      begin
        usb_req_r <= 1'b0;
        cbp_r <= link_r;
      end
      else if (periodic_r && !list_ok)
        usb_req_r <= 1'b0;
    end
    else if (!ack_r)
    begin
      if (go)
      begin
        usb_req_r <= 1'b1;
        periodic_r <= bus.wdata[`OTDE_CMD_PERIODIC_BIT];
        carry_r <= bus.wdata[`OTDE_CMD_CARRY_BIT];
      end
      if (wr_info)
        info_r <= bus.wdata;
      if (wr_cbp)
        cbp_r <= bus.wdata;
      if (wr_be)
        be_r <= bus.wdata;
      if (wr_link)
        link_r <= bus.wdata;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      usb_pid_r <= 1'b0;
      usb_addr_r <= 32'h0;
      carry_out_r <= 1'b0;
    end
    else
    begin
      usb_pid_r <= tog_cur;
      usb_addr_r <= cbp_r;
      carry_out_r <= carry_r;
    end
  end
  assign bus.rdata = rdata_r;
  assign bus.ack = ack_r;
  assign bus.irq = irq_r;
endmodule

// ---- otde_host.sv ----
// Purpose: host end: Avalon-MM slave turning software orders into register accesses
// Assumes: device answers each access with ack one cycle after the request
// Notes: enforces write spacing and tracks descriptor resubmission
`timescale 1ns/100ps
`include "otde_regs.svh"
module otde_host
  import otde_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  otde_if.host bus,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq_r
);
  typedef enum logic [1:0] {OTDE_H_IDLE, OTDE_H_GAP, OTDE_H_BUSY} otde_hst_t;
  otde_hst_t st_r;
  logic [7:0] addr_r;
  logic [31:0] wdata_r;
  logic wr_r;
  logic rd_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic [3:0] gap_r;
  logic [2:0] fail_r;
  logic noresp_r;
  wire logic local_hit = avs_address == `OTDE_OFS_HOST_STAT;
  wire logic req = (avs_read || avs_write) && wait_r;
  // failed retire = completion code pid-fail or no-response read back from the info word
  wire logic [3:0] cc_rd = bus.rdata[`OTDE_INFO_CC_LSB +: 4];
  wire logic info_rd = rd_r && addr_r == `OTDE_OFS_TD_INFO && bus.ack;
  wire logic failed = cc_rd == `OTDE_CC_PIDFAIL || cc_rd == `OTDE_CC_NORESP;
  wire logic [31:0] hst = {28'h0, noresp_r, st_r == OTDE_H_GAP, 1'b0, st_r == OTDE_H_BUSY};
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st_r <= OTDE_H_IDLE;
      addr_r <= 8'h0;
      wdata_r <= 32'h0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rdata_r <= 32'h0;
      wait_r <= 1'b1;
      gap_r <= 4'h0;
      fail_r <= 3'h0;
      noresp_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= bus.irq;
      wait_r <= 1'b1;
      if (gap_r != 4'h0)
        gap_r <= gap_r - 4'h1;
      case (st_r)
        OTDE_H_IDLE:
          if (req && local_hit)
          begin
            rdata_r <= hst;
            wait_r <= 1'b0;
          end
          else if (req && (gap_r == 4'h0 || !avs_write))
          begin
            addr_r <= avs_address;
            wdata_r <= avs_writedata;
            wr_r <= avs_write;
            rd_r <= avs_read;
            st_r <= OTDE_H_BUSY;
          end
        OTDE_H_BUSY:
          if (bus.ack)
          begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            rdata_r <= bus.rdata;
            wait_r <= 1'b0;
            st_r <= OTDE_H_GAP;
            if (wr_r)
              gap_r <= 4'(`OTDE_WR_GAP_CYC);
          end
        OTDE_H_GAP:
          st_r <= OTDE_H_IDLE;
        default:
          st_r <= OTDE_H_IDLE;
      endcase
      if (info_rd)
      begin
        if (!failed)
          fail_r <= 3'h0;
        else if (fail_r != `OTDE_RESUBMIT_MAX)
          fail_r <= fail_r + 3'h1;
        noresp_r <= failed && fail_r + 3'h1 >= `OTDE_RESUBMIT_MAX;
      end
    end
  end
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
endmodule

// ---- otde_chk.sv ----
// Purpose: watches the register port between the host end and the device end
// Assumes: one clock, rstn synchronous active low
// Notes: sees the interface signals only
`timescale 1ns/100ps
`include "otde_regs.svh"
module otde_chk
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic irq
);
  // ****
  // helpers
  // ****
  logic [3:0] gap_r;
  logic lim_wr_r;
  wire logic wr_take = wr && !ack;
  wire logic rd_info = ack && rd && addr == `OTDE_OFS_TD_INFO;
  // gap saturates so a long idle never wraps into a false short gap
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      gap_r <= 4'hf;
      lim_wr_r <= 1'b0;
    end
    else
    begin
      gap_r <= wr_take ? 4'h1 : gap_r + {3'h0, gap_r != 4'hf};
      lim_wr_r <= lim_wr_r | (wr_take && addr == `OTDE_OFS_RETRY_LIMIT);
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ****
  // assertions
  // ****
  AST_ACK_NEXT: assert property ((wr || rd) && !ack |=> ack)
    else $error("ack not one cycle after request");
  AST_ACK_DROP: assert property (ack |=> !ack && !wr && !rd)
    else $error("ack or request not dropped");
  AST_RW_EXCL: assert property (!(wr && rd))
    else $error("read and write together");
  AST_WR_HOLD: assert property (wr_take |=> wr && $stable(addr) && $stable(wdata))
    else $error("write request not held");
  AST_WR_GAP: assert property (wr_take |-> gap_r >= `OTDE_WR_GAP_CYC)
    else $error("writes too close");
  AST_LIM_RST: assert property (ack && rd && addr == `OTDE_OFS_RETRY_LIMIT && !lim_wr_r |->
    rdata[7:0] == `OTDE_RETRY_LIMIT_RST)
    else $error("retry limit not at default");
  AST_TALLY_MAX: assert property (rd_info |-> rdata[27:26] != 2'h3)
    else $error("error tally past two");
  AST_CODE_SET: assert property (rd_info |-> rdata[31:28] inside {4'h0, 4'h5, 4'h6})
    else $error("unexpected completion code");
  cover property (wr_take && addr == 8'h14);
  cover property (rd_info && rdata[31:28] == 4'h5);
  cover property ($rose(irq));
endmodule

// ---- tb_top.sv ----
// Purpose: drives both ends through the Avalon side and the usb and bus strobes
// Assumes: 50 MHz clock, rstn synchronous active low
// Notes: each scenario task judges its own results
`timescale 1ns/100ps
`include "otde_regs.svh"
`define CHK(nm, e, s) \
  begin \
    n_checks++; \
    if ((s) !== (e)) \
    begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", nm, e, s); \
    end \
  end
module tb_top
  import otde_pkg::*;
;
  logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, irq_r, usb_vld, bm_vld;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, usb_addr_r, q;
  otde_usb_res_t usb_res;
  otde_bus_res_t bm_res;
  logic [10:0] usb_len;
  logic usb_req_r, usb_pid_r, carry_out_r;
  int miscompares;
  int n_checks;
  otde_if u_otde_if();
  otde_host u_otde_host (.clk_sys(clk_sys), .rstn(rstn), .bus(u_otde_if.host),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_r(irq_r));
  otde_dev u_otde_dev (.clk_sys(clk_sys), .rstn(rstn), .bus(u_otde_if.dev),
    .usb_vld(usb_vld), .usb_res(usb_res), .usb_len(usb_len), .bm_vld(bm_vld),
    .bm_res(bm_res), .usb_req_r(usb_req_r), .usb_pid_r(usb_pid_r),
    .usb_addr_r(usb_addr_r), .carry_out_r(carry_out_r));
  otde_chk u_otde_chk (.clk_sys(clk_sys), .rstn(rstn), .addr(u_otde_if.addr),
    .wdata(u_otde_if.wdata), .wr(u_otde_if.wr), .rd(u_otde_if.rd),
    .rdata(u_otde_if.rdata), .ack(u_otde_if.ack), .irq(u_otde_if.irq));
  // ****
  // bus and strobe tasks
  // ****
  // called just after a rising edge; holds the request until waitrequest is seen low
  // and lets one edge pass after release so the next call never re-assigns in one step
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic usb(input otde_usb_res_t r);
    @(posedge clk_sys);
    usb_res <= r;
    usb_vld <= 1'b1;
    @(posedge clk_sys);
    usb_vld <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic bm(input otde_bus_res_t r, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      bm_res <= r;
      bm_vld <= 1'b1;
      @(posedge clk_sys);
      bm_vld <= 1'b0;
    end
    repeat (2) @(posedge clk_sys);
  endtask
  // go is refused while a descriptor is active, so it is safe to repeat
  task automatic pk(input otde_usb_res_t r);
    av(1'b1, 8'h18, 32'h1);
    usb(r);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    av(1'b0, 8'h14, 32'h0);
    `CHK("limit", `OTDE_RETRY_LIMIT_RST, q[7:0]);
    av(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q);
    av(1'b1, 8'h14, 32'h11);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    av(1'b0, 8'h14, 32'h0);
    `CHK("limit", `OTDE_RETRY_LIMIT_RST, q[7:0]);
  endtask
  task automatic t_retry();
    av(1'b1, 8'h14, 32'h2);
    av(1'b1, 8'h20, 32'h1000);
    av(1'b1, 8'h24, 32'h1007);
    av(1'b1, 8'h28, 32'h3000);
    av(1'b1, 8'h1c, 32'h0);
    av(1'b1, 8'h18, 32'h1);
    bm(OTDE_BUS_RETRY, 2);
    bm(OTDE_BUS_OK, 1);
    bm(OTDE_BUS_RETRY, 2);
    av(1'b0, 8'h10, 32'h0);
    `CHK("host err", 1'b0, q[4]);
    bm(OTDE_BUS_RETRY, 1);
    av(1'b0, 8'h10, 32'h0);
    `CHK("host err", 1'b1, q[4]);
    av(1'b0, 8'h04, 32'h0);
    `CHK("fatal", 1'b1, q[4]);
    `CHK("irq masked", 1'b0, irq_r);
    av(1'b1, 8'h08, 32'h10);
    `CHK("irq gated", 1'b0, irq_r);
    av(1'b1, 8'h00, 32'h8000_0000);
    `CHK("irq", 1'b1, irq_r);
    av(1'b1, 8'h04, 32'h10);
    av(1'b1, 8'h10, 32'h10);
    av(1'b0, 8'h10, 32'h0);
    `CHK("irq off", 1'b0, irq_r);
    `CHK("host err", 1'b0, q[4]);
  endtask
  task automatic t_zero();
    av(1'b1, 8'h14, 32'h0);
    bm(OTDE_BUS_RETRY, 12);
    av(1'b0, 8'h10, 32'h0);
    `CHK("host err", 1'b0, q[4]);
  endtask
  task automatic t_toggle();
    logic [1:0] t;
    logic e;
    // one 8-byte packet ends the 8-byte descriptor left active by the retry scenario
    usb(OTDE_USB_ACK);
    `CHK("retired", 1'b0, usb_req_r);
    for (int i = 0; i < 4; i++)
    begin
      t = i[1:0];
      e = t[1] ? t[0] : ~t[0];
      av(1'b1, 8'h1c, {6'h0, t, 24'h0});
      av(1'b1, 8'h20, 32'h1000);
      av(1'b1, 8'h18, {29'h0, ~t[0], 2'b01});
      `CHK("pid", e, usb_pid_r);
      usb(OTDE_USB_ACK);
      `CHK("carry", ~e, carry_out_r);
      av(1'b0, 8'h1c, 32'h0);
      `CHK("toggle", {1'b1, ~e}, q[25:24]);
      `CHK("tally", 2'h0, q[27:26]);
      `CHK("code", `OTDE_CC_NOERR, q[31:28]);
    end
    // 32-byte buffer: three packets advance the pointer, the fourth retires it
    av(1'b1, 8'h24, 32'h101f);
    av(1'b1, 8'h20, 32'h1000);
    av(1'b1, 8'h18, 32'h1);
    repeat (3) usb(OTDE_USB_ACK);
    `CHK("addr", 32'h1018, usb_addr_r);
    av(1'b0, 8'h20, 32'h0);
    `CHK("buffer", 32'h1018, q);
    usb(OTDE_USB_ACK);
    `CHK("done", 1'b0, usb_req_r);
    av(1'b0, 8'h20, 32'h0);
    `CHK("link", 32'h3000, q);
  endtask
  task automatic t_err();
    av(1'b1, 8'h1c, 32'h0);
    pk(OTDE_USB_PIDFAIL);
    av(1'b0, 8'h1c, 32'h0);
    `CHK("tally", 2'h1, q[27:26]);
    `CHK("code", `OTDE_CC_PIDFAIL, q[31:28]);
    pk(OTDE_USB_ACK);
    av(1'b0, 8'h1c, 32'h0);
    `CHK("tally", 2'h0, q[27:26]);
    pk(OTDE_USB_NORESP);
    pk(OTDE_USB_NORESP);
    av(1'b0, 8'h1c, 32'h0);
    `CHK("tally", `OTDE_EC_MAX, q[27:26]);
    pk(OTDE_USB_NORESP);
    `CHK("retired", 1'b0, usb_req_r);
    av(1'b0, 8'h1c, 32'h0);
    `CHK("code", `OTDE_CC_NORESP, q[31:28]);
    av(1'b0, 8'h20, 32'h0);
    `CHK("link", 32'h3000, q);
    av(1'b0, 8'h2c, 32'h0);
    `CHK("give up", 1'b0, q[3]);
    repeat (3) av(1'b0, 8'h1c, 32'h0);
    av(1'b0, 8'h2c, 32'h0);
    `CHK("give up", 1'b1, q[3]);
  endtask
  task automatic t_gate();
    for (int i = 1; i < 4; i++)
    begin
      av(1'b1, 8'h00, 32'(i) << 2);
      av(1'b1, 8'h18, 32'h3);
      `CHK("periodic", i == 3, usb_req_r);
    end
    usb(OTDE_USB_ACK);
    av(1'b1, 8'h00, 32'h0);
    `CHK("periodic stop", 1'b0, usb_req_r);
  endtask
  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****
  // clock, sequence and watchdog
  // ****
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    rstn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    usb_vld = 1'b0;
    usb_res = OTDE_USB_ACK;
    usb_len = 11'h008;
    bm_vld = 1'b0;
    bm_res = OTDE_BUS_OK;
    miscompares = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_retry();
    t_zero();
    t_toggle();
    t_err();
    t_gate();
    stop_test();
  end
  // the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
endmodule
